/* core/serial_port.sv */
// Enhanced serial port: APB registers, synchronous shift mode and async modes.
// Assumes inputs synchronous to clock and a one-cycle timer overflow pulse.
`timescale 1ns/1ps
`default_nettype none
module serial_port (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic timer_overflow,
  input wire logic rxd_in,
  output logic rxd_out,
  output logic rxd_oe,
  output logic txd
);
  import serial_port_pkg::*;

  logic [7:0] ctrl_r, pwr_r, slv_addr_r, smask_r, buf_r;
  logic [1:0] mode;
  logic wr_en, rd_en, wr_ctrl, wr_buf;
  assign mode = {ctrl_r[bit_msh], ctrl_r[bit_msl]};
  assign wr_en = psel && penable && pwrite;
  assign rd_en = psel && penable && !pwrite;
  assign wr_ctrl = wr_en && paddr == ctrl_addr;
  assign wr_buf = wr_en && paddr == buf_addr;

  function automatic logic majority(input logic [2:0] s);
    majority = (s[0] & s[1]) | (s[0] & s[2]) | (s[1] & s[2]);
  endfunction : majority

  // Index of the stop bit of a 10-bit or an 11-bit frame.
  function automatic logic [3:0] frame_last(input logic long_frame);
    if (long_frame) begin
      frame_last = frm_last_long;
    end else begin
      frame_last = frm_last_short;
    end
  endfunction : frame_last

  function automatic logic [5:0] tick_top(input logic dbl);
    if (dbl) begin
      tick_top = m2_div_fast;
    end else begin
      tick_top = m2_div_slow;
    end
  endfunction : tick_top

  // Baud tick at 16x bit rate for async modes.
  logic [5:0] pre_r;
  logic tick16;
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      pre_r <= 6'h00;
    end else if (pre_r == tick_top(pwr_r[bit_dbl])) begin
      pre_r <= 6'h00;
    end else begin
      pre_r <= pre_r + 6'h01;
    end
  end
  // Timer modes divide the overflow by 16; the fixed mode divides system clock by 64 or 32 overall.
  assign tick16 = mode[0] ? timer_overflow
                : (pre_r == tick_top(pwr_r[bit_dbl]));

  // Transmit side.
  logic [3:0] tdiv_r;
  logic [8:0] tsh_r;
  logic [3:0] tcnt_r;
  logic tpend_r, tact_r, tdone_set;
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      tdiv_r <= 4'h0;
    end else if (tick16) begin
      tdiv_r <= tdiv_r + 4'h1;
    end
  end

  // Shift clock for mode 0.
  logic [3:0] sdiv_r;
  logic sclk_r, sfall, srise, sh_busy;
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      sdiv_r <= 4'h0;
      sclk_r <= 1'b1;
    end else if (!sh_busy) begin
      sdiv_r <= 4'h0;
      sclk_r <= 1'b1;
    end else if (sdiv_r[2:0] == 3'h0 && sdiv_r == 4'h0) begin
      if (ctrl_r[bit_mp]) begin
        sdiv_r <= sh_half_fast;
      end else begin
        sdiv_r <= sh_half_slow;
      end
      sclk_r <= ~sclk_r;
    end else begin
      sdiv_r <= sdiv_r - 4'h1;
    end
  end
  // Half periods of 2 or 6 clocks give /4 or /12.
  assign sfall = sh_busy && sdiv_r == 4'h0 && sclk_r;
  assign srise = sh_busy && sdiv_r == 4'h0 && !sclk_r;

  logic rbusy0_r;
  assign sh_busy = (mode == 2'b00) && (tact_r || rbusy0_r);

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      tsh_r <= 9'h000;
      tcnt_r <= 4'h0;
      tpend_r <= 1'b0;
      tact_r <= 1'b0;
      tdone_set <= 1'b0;
    end else begin
      tdone_set <= 1'b0;
      if (wr_buf && !tact_r) begin
        tsh_r <= {ctrl_r[bit_tx9], pwdata[7:0]};
        tcnt_r <= 4'h0;
        if (mode == 2'b00) begin
          tact_r <= 1'b1;
        end else begin
          tpend_r <= 1'b1;
        end
      end else if (mode == 2'b00) begin
        tpend_r <= 1'b0;
        // The first falling edge only opens bit 0, so the far side samples it on the first rise.
        // The ninth falling edge closes the frame and is never shown on the line.
        if (tact_r && sfall) begin
          if (tcnt_r != 4'h0) begin
            tsh_r <= {1'b0, tsh_r[8:1]};
          end
          tcnt_r <= tcnt_r + 4'h1;
          if (tcnt_r == m0_end) begin
            tact_r <= 1'b0;
            tdone_set <= 1'b1;
          end
        end
      end else if (tpend_r && tick16 && tdiv_r == smp_last) begin
        tpend_r <= 1'b0;
        tact_r <= 1'b1;
        tcnt_r <= 4'h0;
      end else if (tact_r && tick16 && tdiv_r == smp_last) begin
        tcnt_r <= tcnt_r + 4'h1;
        if (tcnt_r != 4'h0) begin
          tsh_r <= {1'b1, tsh_r[8:1]};
        end
        if (tcnt_r == frame_last(mode[1]) - 4'h1) begin
          tdone_set <= 1'b1;
        end
        if (tcnt_r == frame_last(mode[1])) begin
          tact_r <= 1'b0;
        end
      end
    end
  end

  // Line levels: start, data, stop; idle high outside a frame.
  logic last_bit;
  assign last_bit = tcnt_r == frame_last(mode[1]);
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      txd <= 1'b1;
    end else if (mode == 2'b00) begin
      txd <= sh_busy ? sclk_r : 1'b1;
    end else if (!tact_r) begin
      txd <= 1'b1;
    end else if (tcnt_r == 4'h0) begin
      txd <= 1'b0;
    end else if (last_bit) begin
      txd <= 1'b1;
    end else begin
      txd <= tsh_r[0];
    end
  end
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      rxd_out <= 1'b1;
    end else begin
      rxd_out <= tsh_r[0];
    end
  end
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      rxd_oe <= 1'b0;
    end else begin
      rxd_oe <= (mode == 2'b00) && tact_r;
    end
  end

  // Receive side.
  logic [3:0] rdiv_r, rcnt_r;
  logic [8:0] rsh_r;
  logic [2:0] smp_r;
  logic rhunt_prev_r, ract_r, rdone_set, rx9_val;
  logic [7:0] rdata_val;
  logic given_match;
  logic bit_val;
  assign given_match = ((rsh_r[7:0] ^ slv_addr_r) & smask_r) == 8'h00;
  assign bit_val = majority({rxd_in, smp_r[1:0]});

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      rdiv_r <= 4'h0;
      rcnt_r <= 4'h0;
      rsh_r <= 9'h000;
      smp_r <= 3'h0;
      rhunt_prev_r <= 1'b1;
      ract_r <= 1'b0;
      rbusy0_r <= 1'b0;
      rdone_set <= 1'b0;
      rx9_val <= 1'b0;
      rdata_val <= 8'h00;
    end else begin
      rdone_set <= 1'b0;
      if (mode == 2'b00) begin
        ract_r <= 1'b0;
        // The done flag lands one clock after the set pulse, so the pulse itself also blocks a restart.
        if (!rbusy0_r && !tact_r && ctrl_r[bit_ren] && !ctrl_r[bit_rdone] && !rdone_set) begin
          rbusy0_r <= 1'b1;
          rcnt_r <= 4'h0;
        end else if (rbusy0_r && srise) begin
          rsh_r <= {1'b0, rxd_in, rsh_r[7:1]};
          rcnt_r <= rcnt_r + 4'h1;
          if (rcnt_r == m0_last) begin
            rbusy0_r <= 1'b0;
            rdone_set <= 1'b1;
            rdata_val <= {rxd_in, rsh_r[7:1]};
            rx9_val <= ctrl_r[bit_rx9];
          end
        end
      end else if (!ctrl_r[bit_ren]) begin
        ract_r <= 1'b0;
        rbusy0_r <= 1'b0;
      end else if (tick16) begin
        rbusy0_r <= 1'b0;
        rhunt_prev_r <= rxd_in;
        if (!ract_r) begin
          if (rhunt_prev_r && !rxd_in) begin
            ract_r <= 1'b1;
            rdiv_r <= 4'h0;
            rcnt_r <= 4'h0;
          end
        end else begin
          rdiv_r <= rdiv_r + 4'h1;
          if (rdiv_r == smp_a) begin
            smp_r[0] <= rxd_in;
          end
          if (rdiv_r == smp_b) begin
            smp_r[1] <= rxd_in;
          end
          if (rdiv_r == smp_c) begin
            smp_r[2] <= rxd_in;
            if (rcnt_r == 4'h0 && bit_val) begin
              ract_r <= 1'b0;
            end else if (rcnt_r == frame_last(mode[1])) begin
              ract_r <= 1'b0;
              if (!ctrl_r[bit_rdone]) begin
                if (mode[1]) begin
                  if (!ctrl_r[bit_mp] || (rsh_r[8] && given_match)) begin
                    rdone_set <= 1'b1;
                    rdata_val <= rsh_r[7:0];
                    rx9_val <= rsh_r[8];
                  end
                end else if (!ctrl_r[bit_mp] || bit_val) begin
                  rdone_set <= 1'b1;
                  rdata_val <= rsh_r[8:1];
                  rx9_val <= bit_val;
                end
              end
            end else begin
              rsh_r <= {bit_val, rsh_r[8:1]};
            end
            if (rcnt_r != frame_last(mode[1])) begin
              rcnt_r <= rcnt_r + 4'h1;
            end
          end
        end
      end
    end
  end

  // Registers; hardware set of a done flag wins over a software clear.
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      ctrl_r <= ctrl_reset;
    end else begin
      if (wr_ctrl) begin
        ctrl_r <= pwdata[7:0];
      end
      if (tdone_set) begin
        ctrl_r[bit_tdone] <= 1'b1;
      end
      if (rdone_set) begin
        ctrl_r[bit_rdone] <= 1'b1;
        ctrl_r[bit_rx9] <= rx9_val;
      end
    end
  end
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      buf_r <= 8'h00;
    end else if (rdone_set) begin
      buf_r <= rdata_val;
    end
  end
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      pwr_r <= pwr_reset;
    end else if (wr_en && paddr == pwr_addr) begin
      pwr_r <= pwdata[7:0];
    end
  end
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      slv_addr_r <= addr_reset;
    end else if (wr_en && paddr == slv_addr_addr) begin
      slv_addr_r <= pwdata[7:0];
    end
  end
  // A cleared mask makes every address match, so selective reception is off after reset.
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      smask_r <= addr_reset;
    end else if (wr_en && paddr == smask_addr) begin
      smask_r <= pwdata[7:0];
    end
  end

  logic mapped;
  assign mapped = paddr == ctrl_addr || paddr == buf_addr || paddr == pwr_addr
               || paddr == slv_addr_addr || paddr == smask_addr || paddr == stat_addr;
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel && !pready;
      // Decided in the setup cycle, since penable is still low when pready is raised.
      pslverr <= psel && !pready && !mapped;
      prdata <= 32'h0000_0000;
      if (psel && !pwrite) begin
        case (paddr)
          ctrl_addr: begin
            prdata <= {24'h000000, ctrl_r};
          end
          buf_addr: begin
            prdata <= {24'h000000, buf_r};
          end
          pwr_addr: begin
            prdata <= {24'h000000, pwr_r};
          end
          slv_addr_addr: begin
            prdata <= {24'h000000, slv_addr_r};
          end
          smask_addr: begin
            prdata <= {24'h000000, smask_r};
          end
          stat_addr: begin
            prdata <= {29'h0, tpend_r, tact_r, ract_r | rbusy0_r};
          end
          default: begin
            prdata <= 32'h0000_0000;
          end
        endcase
      end
    end
  end
  logic unused_rd;
  assign unused_rd = rd_en;
endmodule : serial_port
`default_nettype wire

/* inc/serial_port_pkg.sv */
// Constants, register map and mode codes for the enhanced serial port.
// Assumes a 40 MHz system clock and a 32-bit APB register bus.
// What this block does
// - Two mode bits pick shift, 10-bit async, 11-bit fixed-rate or 11-bit async.
// - Mode 0 moves data on the receive line and drives shift clock out while shifting, idle high.
// - Mode 0 frames are eight data bits, LSB first, no framing bits.
// - Mode 0 shift clock is system clock /12, or /4 when rate bit set.
// - Buffer write starts mode 0 send next clock; shift right on falling edges.
// - After eight bits, mode 0 send ends and sets transmit-done next clock.
// - Mode 0 receive starts when receive enabled and receive-done is clear.
// - Mode 0 latches receive line on shift clock rising edge, shifting right.
// - After eight bits receive-done sets; no new reception until it is cleared.
// - Mode 1 frame: start 0, eight data LSB first, stop 1 into ninth flag.
// - Mode 1 bit rate is timer overflow rate divided by sixteen.
// - Async send starts after next divide-by-16 rollover following the write.
// - Mode 1 sends start, data, stop; transmit-done sets as stop goes out.
// - Async receive needs enable; sample at 16x; falling edge resets counter.
// - Each bit is the majority of samples at counter states seven to nine.
// - A start bit sampled high aborts reception and resumes edge hunting.
// - Mode 1 frame stored only if done clear and multiproc bit clear or stop high.
// - Mode 2 frame: start, eight data, programmable ninth, stop; stop not stored.
// - Mode 2 bit rate is system clock over 32 or 64 by rate doubler.
// - Mode 2 buffer write copies transmit ninth bit into shift register.
// - Mode 2 sends start, nine bits, stop; done at eleventh rollover.
// - Mode 2 frame stored only if done clear and multiproc clear or addressed.
// - Rate doubler zero selects divide by 64, one selects divide by 32.
// - Given address compares only bit positions where the mask holds one.
// - Mode 3 uses the 11-bit frame with timer-overflow bit rate.
package serial_port_pkg;
  localparam logic [7:0] ctrl_addr = 8'h00;
  localparam logic [7:0] buf_addr = 8'h04;
  localparam logic [7:0] pwr_addr = 8'h08;
  localparam logic [7:0] slv_addr_addr = 8'h0C;
  localparam logic [7:0] smask_addr = 8'h10;
  localparam logic [7:0] stat_addr = 8'h14;
  localparam int bit_rdone = 0;
  localparam int bit_tdone = 1;
  localparam int bit_rx9 = 2;
  localparam int bit_tx9 = 3;
  localparam int bit_ren = 4;
  localparam int bit_mp = 5;
  localparam int bit_msl = 6;
  localparam int bit_msh = 7;
  localparam int bit_dbl = 7;
  localparam logic [7:0] ctrl_reset = 8'h00;
  localparam logic [7:0] pwr_reset = 8'h00;
  localparam logic [7:0] addr_reset = 8'h00;
  localparam logic [3:0] sh_div_slow = 4'hB;
  localparam logic [3:0] sh_div_fast = 4'h3;
  localparam logic [5:0] m2_div_slow = 6'h03;
  localparam logic [5:0] m2_div_fast = 6'h01;
  localparam logic [3:0] smp_a = 4'h7;
  localparam logic [3:0] smp_b = 4'h8;
  localparam logic [3:0] smp_c = 4'h9;
  localparam logic [3:0] smp_last = 4'hF;
  localparam logic [3:0] sh_half_slow = 4'h5;
  localparam logic [3:0] sh_half_fast = 4'h1;
  localparam logic [3:0] m0_last = 4'h7;
  localparam logic [3:0] m0_end = 4'h8;
  localparam logic [3:0] frm_last_short = 4'h9;
  localparam logic [3:0] frm_last_long = 4'hA;
  typedef enum logic [1:0] {mode_shift, mode_async8, mode_fixed9, mode_async9} mode_e;
endpackage : serial_port_pkg

/* verification/serial_port_chk.sv */
// Checker on the serial port top-level ports.
// Assumes the shift rate and mode stay fixed while a frame is in flight.
`timescale 1ns/1ps
`default_nettype none
module serial_port_chk
  import serial_port_pkg::*;
(
  input wire logic clock,
  input wire logic rst_b,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic txd,
  input wire logic rxd_oe
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_b);
  logic [1:0] mode_r;
  logic fast_r;
  wire logic wr_c = psel && penable && pready && pwrite;
  // Mode is mirrored from control writes, since the ports do not show it.
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      mode_r <= 2'h0;
      fast_r <= 1'b0;
    end else if (wr_c && paddr == ctrl_addr) begin
      mode_r <= pwdata[bit_msh:bit_msl];
      fast_r <= pwdata[bit_mp];
    end
  end
  sequence s_lo_fast; !txd ##1 txd; endsequence
  sequence s_lo_slow; (!txd)[*5] ##1 txd; endsequence
  property p_ack; psel && !penable |=> pready; endproperty
  a_ack: assert property (p_ack) else $error("pready not one cycle after setup");
  property p_pulse; pready |=> !pready; endproperty
  a_pulse: assert property (p_pulse) else $error("pready held too long");
  property p_ctx; pready |-> psel && penable; endproperty
  a_ctx: assert property (p_ctx) else $error("pready outside access phase");
  property p_err; pslverr |-> pready && (pwrite || prdata == 32'h0); endproperty
  a_err: assert property (p_err) else $error("error response malformed");
  property p_oe; rxd_oe |-> mode_r == 2'h0; endproperty
  a_oe: assert property (p_oe) else $error("data line driven outside shift mode");
  property p_sclk_f; mode_r == 2'h0 && fast_r && $fell(txd) |=> s_lo_fast; endproperty
  a_sclk_f: assert property (p_sclk_f) else $error("fast shift clock wrong");
  property p_sclk_s; mode_r == 2'h0 && !fast_r && $fell(txd) |=> s_lo_slow; endproperty
  a_sclk_s: assert property (p_sclk_s) else $error("slow shift clock wrong");
  property p_start; wr_c && paddr == buf_addr && mode_r == 2'h2 |-> ##[1:70] !txd; endproperty
  a_start: assert property (p_start) else $error("start bit late");
endmodule : serial_port_chk
bind serial_port serial_port_chk u_chk (.clock(clock), .rst_b(rst_b), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .txd(txd), .rxd_oe(rxd_oe));
`default_nettype wire

/* verification/serial_peer.sv */
// Far side: shift device for mode 0 and async node for the other modes.
// Assumes a pull-up on the data line, so a released line reads 1.
`timescale 1ns/1ps
`default_nettype none
module serial_peer (
  input wire logic clock,
  input wire logic txd,
  input wire logic rxd_out,
  input wire logic rxd_oe,
  output logic rxd_in
);
  logic m0_on = 1'b0;
  logic m0_line = 1'b1;
  logic tx_line = 1'b1;
  logic txd_q = 1'b1;
  logic [7:0] sh = 8'h00;
  logic [7:0] got = 8'h00;
  assign rxd_in = rxd_oe ? rxd_out : (m0_on ? m0_line : tx_line);
  always @(posedge clock) begin
    txd_q <= txd;
    if (rxd_oe && txd && !txd_q) begin
      got <= {rxd_out, got[7:1]};
    end
  end
  // Data follows the falling shift clock at once, since the fast rise comes one clock later.
  always @(negedge txd) begin
    if (m0_on && !rxd_oe) begin
      m0_line <= sh[0];
      sh <= {1'b1, sh[7:1]};
    end
  end
  task automatic send(input logic [10:0] f, input int nb, input int bt);
    for (int i = 0; i < nb; i++) begin
      tx_line <= f[i];
      repeat (bt) @(posedge clock);
    end
    tx_line <= 1'b1;
  endtask : send
endmodule : serial_peer
`default_nettype wire

/* verification/serial_port_tb_top.sv */
// Self-checking bench: APB master, line peer and timer pulses every 2 clocks.
// Assumes the zero-wait-state APB answer of the design.
`timescale 1ns/1ps
`default_nettype none
module serial_port_tb_top;
  import serial_port_pkg::*;
  logic clock = 1'b0;
  logic rst_b = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic timer_overflow = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rq;
  logic pready, pslverr, re, rxd_in, rxd_out, rxd_oe, txd;
  int err_count = 0;
  int num_checks = 0;
  serial_port u_serial_port (.clock(clock), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .timer_overflow(timer_overflow), .rxd_in(rxd_in), .rxd_out(rxd_out), .rxd_oe(rxd_oe), .txd(txd));
  serial_peer u_peer (.clock(clock), .txd(txd), .rxd_out(rxd_out), .rxd_oe(rxd_oe), .rxd_in(rxd_in));
  initial begin
    forever #12.5 clock = ~clock;
  end
  // Overflow every 2 clocks gives a 32-clock bit, the same as mode 2 doubled.
  always @(posedge clock) timer_overflow <= !timer_overflow;
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    do begin
      @(posedge clock);
    end while (pready !== 1'b1);
    chk({31'h0, pready}, 32'h1);
    rq = prdata;
    re = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic wait_bit(input int b);
    int n;
    n = 0;
    do begin
      apb(1'b0, ctrl_addr, 32'h0);
      n++;
    end while (rq[b] !== 1'b1 && n < 400);
  endtask : wait_bit
  task automatic get_tx(input int nb, output logic [10:0] f);
    int n;
    n = 0;
    f = 11'h0;
    while (txd !== 1'b0 && n < 200) begin
      @(posedge clock);
      n++;
    end
    repeat (16) @(posedge clock);
    for (int i = 0; i < nb; i++) begin
      f[i] = txd;
      repeat (32) @(posedge clock);
    end
  endtask : get_tx
  task automatic t_regs();
    apb(1'b0, ctrl_addr, 32'h0);
    chk(rq, {24'h0, ctrl_reset});
    apb(1'b0, pwr_addr, 32'h0);
    chk(rq, {24'h0, pwr_reset});
    apb(1'b1, 8'h18, 32'hFF);
    chk({31'h0, re}, 32'h1);
    apb(1'b0, 8'h18, 32'h0);
    chk(rq, 32'h0);
    $display("test regs done");
  endtask : t_regs
  task automatic t_m0_tx();
    apb(1'b1, ctrl_addr, 32'h0);
    apb(1'b1, buf_addr, 32'hA5);
    wait_bit(bit_tdone);
    chk(rq, 32'h02);
    chk({24'h0, u_peer.got}, 32'hA5);
    $display("test m0_tx done");
  endtask : t_m0_tx
  task automatic t_m0_rx();
    u_peer.sh = 8'h9C;
    u_peer.m0_on = 1'b1;
    apb(1'b1, ctrl_addr, 32'h30);
    wait_bit(bit_rdone);
    chk(rq, 32'h31);
    repeat (40) @(posedge clock);
    chk({31'h0, txd}, 32'h1);
    apb(1'b0, stat_addr, 32'h0);
    chk(rq, 32'h0);
    apb(1'b0, buf_addr, 32'h0);
    chk(rq, 32'h9C);
    u_peer.m0_on = 1'b0;
    apb(1'b1, ctrl_addr, 32'h20);
    $display("test m0_rx done");
  endtask : t_m0_rx
  task automatic t_async();
    logic [10:0] f, e;
    logic [31:0] c;
    int nb;
    apb(1'b1, pwr_addr, 32'h80);
    for (int m = 1; m < 4; m++) begin
      nb = (m == 1) ? 10 : 11;
      c = (m << 6) | 32'h18;
      e = {(m == 1) ? 2'b01 : 2'b11, 8'h5A, 1'b0};
      apb(1'b1, ctrl_addr, c);
      fork
        begin
          apb(1'b1, buf_addr, 32'h5A);
          get_tx(nb, f);
        end
        u_peer.send({(m == 1) ? 2'b01 : 2'b10, 8'hC3, 1'b0}, nb, 32);
      join
      chk({21'h0, f}, {21'h0, e});
      apb(1'b0, ctrl_addr, 32'h0);
      chk(rq, c | ((m == 1) ? 32'h7 : 32'h3));
      apb(1'b0, buf_addr, 32'h0);
      chk(rq, 32'hC3);
      apb(1'b1, ctrl_addr, c);
    end
    $display("test async done");
  endtask : t_async
  task automatic t_addr();
    logic [8:0] tab [4] = '{9'h1A0, 9'h1A2, 9'h0A1, 9'h1A5};
    logic [3:0] acc = 4'b1001;
    apb(1'b1, slv_addr_addr, 32'hA4);
    apb(1'b1, smask_addr, 32'hFA);
    apb(1'b1, ctrl_addr, 32'hF0);
    // A 6-clock low pulse is gone before the mid-bit samples, so it must abort.
    u_peer.send(11'h7FE, 1, 6);
    repeat (300) @(posedge clock);
    apb(1'b0, ctrl_addr, 32'h0);
    chk(rq, 32'hF0);
    for (int i = 0; i < 4; i++) begin
      u_peer.send({1'b1, tab[i], 1'b0}, 11, 32);
      apb(1'b0, ctrl_addr, 32'h0);
      chk({31'h0, rq[bit_rdone]}, {31'h0, acc[i]});
      apb(1'b0, buf_addr, 32'h0);
      if (acc[i]) chk(rq, {24'h0, tab[i][7:0]});
      apb(1'b1, ctrl_addr, 32'hF0);
    end
    $display("test addr done");
  endtask : t_addr
  task automatic stop_test();
    $display("checks %0d errors %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : stop_test
  initial begin
    repeat (16) @(posedge clock);
    rst_b <= 1'b1;
    t_regs();
    t_m0_tx();
    t_m0_rx();
    t_async();
    t_addr();
    stop_test();
  end
  initial begin
    repeat (40000) @(posedge clock);
    err_count++;
    stop_test();
  end
endmodule : serial_port_tb_top
`default_nettype wire
